// *** core/ifpr_regs.sv ***
// Interrupt flag status and priority control registers with AXI4-Lite access.
// Assumes request inputs are one-cycle or level pulses synchronous to sys_clk.
//
// Functional notes
// - A flag reads 1 after its source requested, 0 if never requested.
// - First flag group: comparator bit 2, I2C1 master bit 1, slave bit 0.
// - Fourth flag group holds ten read/write flags at their listed bits.
// - First priority group: timer2, compare2, capture2, DMA0 three-bit fields.
// - Later priority group: capcomp4, capcomp3, SPI4 transmit, SPI4 general fields.
// - Field value 111 is level 7, the highest priority.
// - Field value 001 is level 1; middle codes map to matching levels.
// - Field value 000 disables the source; it never interrupts.
`timescale 1ns/1ps

module ifpr_regs (
    input wire logic sys_clk, // System clock, 20 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic [2:0] flagReqGrp1, // Requests: comparator, I2C1 master, I2C1 slave
    input wire logic [15:0] flagReqGrp4, // Requests at fourth group flag positions
    input wire logic [ifpr_pkg::PRIO_SOURCES-1:0] prioPending, // Pending flags, prioritised sources
    output logic [2:0] arbLevel, // Highest enabled pending level
    output logic arbValid, // Some enabled source is pending
    output logic irq, // Level interrupt
    input wire logic [9:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [9:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);
    import ifpr_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [2:0] prioField(input logic [15:0] reg16, input int lsb);
        prioField = reg16[lsb +: PRIO_FIELD_W];
    endfunction

    function automatic logic [15:0] applyStrb(input logic [15:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
        applyStrb = old;
        if (strb[0]) begin
            applyStrb[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            applyStrb[15:8] = wd[15:8];
        end
    endfunction

    function automatic logic isMapped(input logic [9:0] addr);
        case (addr)
            OFS_FLAG_GRP1, OFS_FLAG_GRP4, OFS_PRIO_GRP1, OFS_PRIO_GRP23,
            OFS_INT_STATUS, OFS_INT_ENABLE, OFS_INT_CLEAR, OFS_ARB_STATUS: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Write channel
    logic awHave_r;
    logic wHave_r;
    logic [9:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic wrFire;

    assign s_axi_awready = !awHave_r && !s_axi_bvalid;
    assign s_axi_wready = !wHave_r && !s_axi_bvalid;
    // Address and data may arrive in either order; the write acts once both are held
    assign wrFire = awHave_r && wHave_r && !s_axi_bvalid;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            awHave_r <= 1'b0;
            awAddr_r <= 10'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHave_r <= 1'b1;
            awAddr_r <= {s_axi_awaddr[9:2], 2'b00};
        end else if (wrFire) begin
            awHave_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wHave_r <= 1'b0;
            wData_r <= 32'h00000000;
            wStrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHave_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
        end else if (wrFire) begin
            wHave_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wrFlag1;
    logic wrFlag4;
    logic wrPrio1;
    logic wrPrio23;
    logic wrEnable;
    logic wrClear;
    assign wrFlag1 = wrFire && awAddr_r == OFS_FLAG_GRP1;
    assign wrFlag4 = wrFire && awAddr_r == OFS_FLAG_GRP4;
    assign wrPrio1 = wrFire && awAddr_r == OFS_PRIO_GRP1;
    assign wrPrio23 = wrFire && awAddr_r == OFS_PRIO_GRP23;
    assign wrEnable = wrFire && awAddr_r == OFS_INT_ENABLE;
    assign wrClear = wrFire && awAddr_r == OFS_INT_CLEAR;

    // ==========================================================
    // Flag registers
    logic [15:0] flagGrp1_r;
    logic [15:0] flagGrp1_nxt;
    logic [15:0] flagGrp4_r;
    logic [15:0] flagGrp4_nxt;
    logic [15:0] setGrp1;
    logic [15:0] setGrp4;

    assign setGrp1 = {13'h0000, flagReqGrp1} & FLAG_GRP1_MASK;
    assign setGrp4 = flagReqGrp4 & FLAG_GRP4_MASK;

    // A request in the cycle of a clearing write still lands
    always_comb begin
        flagGrp1_nxt = wrFlag1 ? applyStrb(flagGrp1_r, wData_r, wStrb_r) : flagGrp1_r;
        flagGrp1_nxt = (flagGrp1_nxt | setGrp1) & FLAG_GRP1_MASK;
        flagGrp4_nxt = wrFlag4 ? applyStrb(flagGrp4_r, wData_r, wStrb_r) : flagGrp4_r;
        flagGrp4_nxt = (flagGrp4_nxt | setGrp4) & FLAG_GRP4_MASK;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flagGrp1_r <= FLAG_RESET;
            flagGrp4_r <= FLAG_RESET;
        end else begin
            flagGrp1_r <= flagGrp1_nxt;
            flagGrp4_r <= flagGrp4_nxt;
        end
    end

    // ==========================================================
    // Priority registers
    logic [15:0] prioGrp1_r;
    logic [15:0] prioGrp23_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prioGrp1_r <= PRIO_RESET;
            prioGrp23_r <= PRIO_RESET;
        end else begin
            if (wrPrio1) begin
                prioGrp1_r <= applyStrb(prioGrp1_r, wData_r, wStrb_r) & PRIO_MASK;
            end
            if (wrPrio23) begin
                prioGrp23_r <= applyStrb(prioGrp23_r, wData_r, wStrb_r) & PRIO_MASK;
            end
        end
    end

    // ==========================================================
    // Arbitration: pending source order is timer2, compare2, capture2, DMA0,
    // capcomp4, capcomp3, SPI4 transmit, SPI4 general
    logic [2:0] srcLevel [PRIO_SOURCES];
    logic [2:0] bestLevel;

    always_comb begin
        srcLevel[0] = prioField(prioGrp1_r, FIELD_HI_LSB);
        srcLevel[1] = prioField(prioGrp1_r, FIELD_MIDHI_LSB);
        srcLevel[2] = prioField(prioGrp1_r, FIELD_MIDLO_LSB);
        srcLevel[3] = prioField(prioGrp1_r, FIELD_LO_LSB);
        srcLevel[4] = prioField(prioGrp23_r, FIELD_HI_LSB);
        srcLevel[5] = prioField(prioGrp23_r, FIELD_MIDHI_LSB);
        srcLevel[6] = prioField(prioGrp23_r, FIELD_MIDLO_LSB);
        srcLevel[7] = prioField(prioGrp23_r, FIELD_LO_LSB);
        bestLevel = LEVEL_DISABLED;
        for (int i = 0; i < PRIO_SOURCES; i++) begin
            // Code equals level, so 000 can never win over nothing
            if (prioPending[i] && srcLevel[i] > bestLevel) begin
                bestLevel = srcLevel[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            arbLevel <= LEVEL_DISABLED;
            arbValid <= 1'b0;
        end else begin
            arbLevel <= bestLevel;
            arbValid <= bestLevel != LEVEL_DISABLED;
        end
    end

    // ==========================================================
    // Interrupt status, enable and clear
    logic [EVT_W-1:0] intStatus_r;
    logic [EVT_W-1:0] intEnable_r;
    logic [EVT_W-1:0] evt;

    always_comb begin
        evt = EVT_RESET;
        evt[EVT_GRP1_BIT] = |(setGrp1 & ~flagGrp1_r);
        evt[EVT_GRP4_BIT] = |(setGrp4 & ~flagGrp4_r);
        evt[EVT_ARB_BIT] = (bestLevel != LEVEL_DISABLED) && !arbValid;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            intStatus_r <= EVT_RESET;
        end else begin
            intStatus_r <= (intStatus_r & ~(wrClear ? wData_r[EVT_W-1:0] : EVT_RESET)) | evt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            intEnable_r <= EVT_RESET;
        end else if (wrEnable && wStrb_r[0]) begin
            intEnable_r <= wData_r[EVT_W-1:0];
        end
    end

    assign irq = |(intStatus_r & intEnable_r);

    // ==========================================================
    // Read channel: one cycle from address to data
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h00000000;
        case ({s_axi_araddr[9:2], 2'b00})
            OFS_FLAG_GRP1: rdMux[15:0] = flagGrp1_r;
            OFS_FLAG_GRP4: rdMux[15:0] = flagGrp4_r;
            OFS_PRIO_GRP1: rdMux[15:0] = prioGrp1_r;
            OFS_PRIO_GRP23: rdMux[15:0] = prioGrp23_r;
            OFS_INT_STATUS: rdMux[EVT_W-1:0] = intStatus_r;
            OFS_INT_ENABLE: rdMux[EVT_W-1:0] = intEnable_r;
            OFS_ARB_STATUS: rdMux[3:0] = {arbValid, arbLevel};
            default: rdMux = 32'h00000000;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= isMapped({s_axi_araddr[9:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    sequence s_rd_answer;
        s_axi_rvalid [*1];
    endsequence

    a_flag_request_sets: assert property (
        flagReqGrp1[COMPARATOR_REQ_FLAG_BIT] |=> flagGrp1_r[COMPARATOR_REQ_FLAG_BIT]
    ) else $error("comparator flag not set by request");

    a_flag_stays_set: assert property (
        (flagGrp4_r[0] && !wrFlag4) |=> flagGrp4_r[0]
    ) else $error("flag dropped without a write");

    a_flag_unimpl_zero: assert property (
        (flagGrp4_r & ~FLAG_GRP4_MASK) == 16'h0000 && (flagGrp1_r & ~FLAG_GRP1_MASK) == 16'h0000
    ) else $error("unimplemented flag bit set");

    a_prio_unimpl_zero: assert property (
        ((prioGrp1_r | prioGrp23_r) & ~PRIO_MASK) == 16'h0000
    ) else $error("unimplemented priority bit set");

    a_prio_reset_four: assert property (
        $past(rst) |-> (prioGrp1_r == PRIO_RESET && prioGrp23_r == PRIO_RESET)
    ) else $error("priority not level 4 after reset");

    a_arb_highest: assert property (
        (prioPending[7] && prioField(prioGrp23_r, FIELD_LO_LSB) == LEVEL_HIGHEST)
            |=> (arbValid && arbLevel == LEVEL_HIGHEST)
    ) else $error("level 7 source not on top");

    a_arb_lowest: assert property (
        (prioPending == 8'h01 && prioField(prioGrp1_r, FIELD_HI_LSB) == LEVEL_LOWEST)
            |=> (arbValid && arbLevel == LEVEL_LOWEST)
    ) else $error("level 1 source not reported");

    a_arb_disabled: assert property (
        (prioPending == 8'h10 && prioField(prioGrp23_r, FIELD_HI_LSB) == LEVEL_DISABLED)
            |=> !arbValid
    ) else $error("disabled source produced a request");

    a_irq_on_event: assert property (
        ($rose(arbValid) && intEnable_r[EVT_ARB_BIT]) |-> irq
    ) else $error("enabled arbitration event gave no interrupt");

    a_read_answer: assert property (
        s_rd_take |=> s_rd_answer
    ) else $error("read not answered in one cycle");

    sequence s_wr_pair;
        awHave_r && wHave_r && !s_axi_bvalid;
    endsequence

    a_write_answer: assert property (
        s_wr_pair |=> s_axi_bvalid
    ) else $error("write not answered one cycle after address and data");

    a_status_sticky: assert property (
        (intStatus_r[EVT_GRP1_BIT] && !wrClear) |=> intStatus_r[EVT_GRP1_BIT]
    ) else $error("interrupt status dropped without a clear");

endmodule

// *** core/ifpr_pkg.sv ***
// Package for the interrupt flag and priority register block.
// Assumes a 32-bit AXI4-Lite register bus; byte address is four times the register index.
package ifpr_pkg;

    // ==========================================================
    // Register indices; each register is one aligned word
    localparam logic [7:0] IDX_FLAG_GRP1 = 8'h8a;
    localparam logic [7:0] IDX_FLAG_GRP4 = 8'h90;
    localparam logic [7:0] IDX_PRIO_GRP1 = 8'haa;
    localparam logic [7:0] IDX_PRIO_GRP23 = 8'hd6;
    // Interrupt and arbitration registers sit in a free stretch above the rest
    localparam logic [7:0] IDX_INT_STATUS = 8'hf0;
    localparam logic [7:0] IDX_INT_ENABLE = 8'hf1;
    localparam logic [7:0] IDX_INT_CLEAR = 8'hf2;
    localparam logic [7:0] IDX_ARB_STATUS = 8'hf3;

    // Register byte addresses
    localparam logic [9:0] OFS_FLAG_GRP1 = {IDX_FLAG_GRP1, 2'b00};
    localparam logic [9:0] OFS_FLAG_GRP4 = {IDX_FLAG_GRP4, 2'b00};
    localparam logic [9:0] OFS_PRIO_GRP1 = {IDX_PRIO_GRP1, 2'b00};
    localparam logic [9:0] OFS_PRIO_GRP23 = {IDX_PRIO_GRP23, 2'b00};
    localparam logic [9:0] OFS_INT_STATUS = {IDX_INT_STATUS, 2'b00};
    localparam logic [9:0] OFS_INT_ENABLE = {IDX_INT_ENABLE, 2'b00};
    localparam logic [9:0] OFS_INT_CLEAR = {IDX_INT_CLEAR, 2'b00};
    localparam logic [9:0] OFS_ARB_STATUS = {IDX_ARB_STATUS, 2'b00};

    // ==========================================================
    // Implemented bits and reset values
    localparam logic [15:0] FLAG_GRP1_MASK = 16'h0007;
    localparam logic [15:0] FLAG_GRP4_MASK = 16'h63cf;
    localparam logic [15:0] PRIO_MASK = 16'h7777;
    localparam logic [15:0] FLAG_RESET = 16'h0000;
    localparam logic [15:0] PRIO_RESET = 16'h4444;

    // Flag positions, first group
    localparam int COMPARATOR_REQ_FLAG_BIT = 2;
    localparam int I2C_CH1_MASTER_EVENT_FLAG_BIT = 1;
    localparam int I2C_CH1_SLAVE_EVENT_FLAG_BIT = 0;

    // Priority field low bits; each field is three bits wide
    localparam int PRIO_FIELD_W = 3;
    localparam int FIELD_HI_LSB = 12;
    localparam int FIELD_MIDHI_LSB = 8;
    localparam int FIELD_MIDLO_LSB = 4;
    localparam int FIELD_LO_LSB = 0;
    localparam int PRIO_SOURCES = 8;

    // Priority levels
    localparam logic [2:0] LEVEL_DISABLED = 3'h0;
    localparam logic [2:0] LEVEL_LOWEST = 3'h1;
    localparam logic [2:0] LEVEL_HIGHEST = 3'h7;

    // ==========================================================
    // Interrupt status bits
    localparam int EVT_GRP1_BIT = 0;
    localparam int EVT_GRP4_BIT = 1;
    localparam int EVT_ARB_BIT = 2;
    localparam int EVT_W = 3;
    localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** tb/ifpr_src_model.sv ***
// Model of the peripheral sources that raise requests into the flag block.
// Assumes the bench commands it; requests change only after a rising edge.
`timescale 1ns/1ps

module ifpr_src_model (
    input wire logic sys_clk, // System clock
    input wire logic fire, // Bench asks for one request cycle
    input wire logic [2:0] grp1Sel, // Sources to pulse, first group
    input wire logic [15:0] grp4Sel, // Sources to pulse, fourth group
    input wire logic [7:0] pendSel, // Pending levels of prioritised sources
    output logic [2:0] flagReqGrp1, // Requests, first group
    output logic [15:0] flagReqGrp4, // Requests, fourth group
    output logic [7:0] prioPending // Pending, prioritised sources
);
    // ==========================================================
    // Sources
    initial begin
        flagReqGrp1 = 3'h0;
        flagReqGrp4 = 16'h0;
        prioPending = 8'h0;
    end

    // Requests last one cycle so the sticky flag, not the source, holds them
    always @(posedge sys_clk) begin
        flagReqGrp1 <= fire ? grp1Sel : 3'h0;
        flagReqGrp4 <= fire ? grp4Sel : 16'h0;
        prioPending <= pendSel;
    end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the flag and priority register block.
// Assumes the source model drives request pins; the bench is the bus master.
`timescale 1ns/1ps

module tb_top;
    import ifpr_pkg::*;
    logic sys_clk = 0, rst = 1, fire = 0;
    logic [2:0] grp1Sel = 0, flagReqGrp1, arbLevel;
    logic [15:0] grp4Sel = 0, flagReqGrp4, p1, p23;
    logic [7:0] pendSel = 0, prioPending, pend;
    logic [9:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, arbValid, irq;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp;
    logic [34:0] expQ[$];
    int fails = 0, comparisons = 0;

    always #25 sys_clk = ~sys_clk;

    ifpr_src_model i_ifpr_src_model (.sys_clk(sys_clk), .fire(fire), .grp1Sel(grp1Sel),
        .grp4Sel(grp4Sel), .pendSel(pendSel), .flagReqGrp1(flagReqGrp1),
        .flagReqGrp4(flagReqGrp4), .prioPending(prioPending));

    ifpr_regs i_ifpr_regs (.sys_clk(sys_clk), .rst(rst), .flagReqGrp1(flagReqGrp1),
        .flagReqGrp4(flagReqGrp4), .prioPending(prioPending), .arbLevel(arbLevel),
        .arbValid(arbValid), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ==========================================================
    // Checking and closing
    task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Answers are sampled at the falling edge, where they equal what the next edge takes
    always @(negedge sys_clk) begin
        if (bvalid === 1'b1 && bready)
            check("write answer", {1'b1, bresp, 32'h0}, expQ.pop_front());
        if (rvalid === 1'b1 && rready)
            check("read answer", {1'b0, rresp, rdata}, expQ.pop_front());
    end

    // ==========================================================
    // Bus master
    task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                        input logic [1:0] er, input logic [31:0] ed);
        logic hitA, hitW, hitR, done;
        int n;
        expQ.push_back({wr, er, wr ? 32'h0 : ed});
        @(posedge sys_clk);
        if (wr) begin
            awaddr <= a;
            wdata <= d;
            wstrb <= 4'hf;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (n = 0; n < 40; n++) begin
            @(negedge sys_clk);
            hitA = (awready === 1'b1) && awvalid;
            hitW = (wready === 1'b1) && wvalid;
            hitR = (arready === 1'b1) && arvalid;
            done = ((bvalid === 1'b1) && bready) || ((rvalid === 1'b1) && rready);
            @(posedge sys_clk);
            if (hitA) awvalid <= 1'b0;
            if (hitW) wvalid <= 1'b0;
            if (hitR) arvalid <= 1'b0;
            if (done) begin
                bready <= 1'b0;
                rready <= 1'b0;
                return;
            end
        end
        fails++;
        $display("CHECK FAILED bus answer expected handshake seen timeout");
        report_and_stop();
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] ed);
        xfer(1'b0, a, 32'h0, RESP_OKAY, ed);
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, RESP_OKAY, 32'h0);
    endtask

    task automatic pulse(input logic [2:0] g1, input logic [15:0] g4);
        @(posedge sys_clk);
        grp1Sel <= g1;
        grp4Sel <= g4;
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // Highest nonzero field among pending sources, as {valid, level}
    function automatic logic [3:0] arbExp(input logic [15:0] a, input logic [15:0] b,
                                          input logic [7:0] p);
        logic [2:0] f;
        logic [2:0] best;
        best = 3'h0;
        for (int i = 0; i < 8; i++) begin
            f = (i < 4) ? a[12-4*i +: 3] : b[28-4*i +: 3];
            if (p[i] && f > best) best = f;
        end
        return {best != 3'h0, best};
    endfunction

    // ==========================================================
    // Scenarios
    initial begin
        void'($urandom(39));
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        rd(OFS_FLAG_GRP1, 32'h0);
        rd(OFS_FLAG_GRP4, 32'h0);
        rd(OFS_PRIO_GRP1, {16'h0, PRIO_RESET});
        rd(OFS_PRIO_GRP23, {16'h0, PRIO_RESET});
        rd(OFS_INT_ENABLE, 32'h0);
        wr(OFS_PRIO_GRP1, 32'hffff_ffff);
        rd(OFS_PRIO_GRP1, {16'h0, PRIO_MASK});
        wr(OFS_PRIO_GRP23, 32'hffff_ffff);
        rd(OFS_PRIO_GRP23, {16'h0, PRIO_MASK});
        for (int i = 0; i < 3; i++) begin
            pulse(3'h1 << i, 16'h0);
            rd(OFS_FLAG_GRP1, 32'h1 << i);
            wr(OFS_FLAG_GRP1, 32'h0);
            rd(OFS_FLAG_GRP1, 32'h0);
        end
        for (int i = 0; i < 16; i++) begin
            pulse(3'h0, 16'h1 << i);
            rd(OFS_FLAG_GRP4, (32'h1 << i) & 32'h63cf);
            wr(OFS_FLAG_GRP4, 32'h0);
        end
        wr(OFS_FLAG_GRP4, 32'hffff);
        rd(OFS_FLAG_GRP4, 32'h63cf);
        pendSel <= 8'h01;
        for (int l = 0; l < 8; l++) begin
            wr(OFS_PRIO_GRP1, 32'(l) << 12);
            rd(OFS_ARB_STATUS, {28'h0, l != 0, 3'(l)});
        end
        repeat (12) begin
            p1 = 16'($urandom());
            p23 = 16'($urandom());
            pend = 8'($urandom());
            pendSel <= pend;
            wr(OFS_PRIO_GRP1, {16'h0, p1});
            wr(OFS_PRIO_GRP23, {16'h0, p23});
            rd(OFS_ARB_STATUS, {28'h0, arbExp(p1, p23, pend)});
            @(negedge sys_clk);
            check("arbitration pins", 35'({arbValid, arbLevel}), 35'(arbExp(p1, p23, pend)));
            @(posedge sys_clk);
        end
        pendSel <= 8'h0;
        wr(OFS_FLAG_GRP1, 32'h0);
        wr(OFS_FLAG_GRP4, 32'h0);
        wr(OFS_INT_CLEAR, 32'h7);
        rd(OFS_INT_STATUS, 32'h0);
        rd(OFS_INT_CLEAR, 32'h0);
        wr(OFS_INT_ENABLE, 32'h1);
        pulse(3'h4, 16'h0);
        rd(OFS_INT_STATUS, 32'h1);
        @(negedge sys_clk);
        check("irq raised", 35'(irq), 35'h1);
        wr(OFS_INT_ENABLE, 32'h0);
        @(negedge sys_clk);
        check("irq masked", 35'(irq), 35'h0);
        wr(OFS_INT_ENABLE, 32'h1);
        wr(OFS_INT_CLEAR, 32'h1);
        rd(OFS_INT_STATUS, 32'h0);
        @(negedge sys_clk);
        check("irq cleared", 35'(irq), 35'h0);
        // Arbitration event with its enable set before the pending source rises
        wr(OFS_PRIO_GRP1, 32'h1000);
        wr(OFS_INT_ENABLE, 32'h4);
        pendSel <= 8'h01;
        repeat (3) @(posedge sys_clk);
        rd(OFS_ARB_STATUS, 32'h9);
        rd(OFS_INT_STATUS, 32'h4);
        @(negedge sys_clk);
        check("irq on arbitration", 35'(irq), 35'h1);
        wr(OFS_PRIO_GRP23, 32'h0);
        pendSel <= 8'h10;
        repeat (3) @(posedge sys_clk);
        rd(OFS_ARB_STATUS, 32'h0);
        xfer(1'b1, 10'h020, 32'hffff_ffff, RESP_SLVERR, 32'h0);
        xfer(1'b0, 10'h020, 32'h0, RESP_SLVERR, 32'h0);
        report_and_stop();
    end
endmodule
